// ### shared/ssw_pkg.sv
// supply supervisor and watchdog: constants, types and reset values.
// assumes a free-running 100 MHz module clock and synchronous input flags.

package ssw_pkg;

   localparam int CLOCK_PERIOD_NS     = 10;
   localparam int RESET_TIMEOUT_MS    = 200;
   localparam int WATCHDOG_TIMEOUT_MS = 1600;
   localparam int CS_HOLD_US          = 10;

   localparam int RESET_TIMEOUT_CYCLES =
      RESET_TIMEOUT_MS * 1000000 / CLOCK_PERIOD_NS;
   localparam int WATCHDOG_TIMEOUT_CYCLES =
      WATCHDOG_TIMEOUT_MS * 1000000 / CLOCK_PERIOD_NS;
   localparam int CS_HOLD_CYCLES = CS_HOLD_US * 1000 / CLOCK_PERIOD_NS;

   typedef enum logic [2:0]
   {
      PHASE_HOLD    = 3'h1,
      PHASE_STRETCH = 3'h2,
      PHASE_RUN     = 3'h4
   } ssw_phase_type;

   typedef struct packed
   {
      logic belowReset;
      logic belowSwitch;
      logic belowCell;
      logic cellGoodLevel;
      logic powerFailSenseIn;
      logic atWarningLevel;
   } ssw_flags_type;

   typedef struct packed
   {
      logic resetN;
      logic resetHigh;
      logic watchdogFaultN;
      logic chipSelectOutN;
      logic powerFailFlagN;
      logic backupActive;
      logic backupGood;
      logic supplyLowWarningN;
   } ssw_status_type;

   localparam ssw_status_type STATUS_RESET = '{
      resetN: 1'b0, resetHigh: 1'b1, watchdogFaultN: 1'b1,
      chipSelectOutN: 1'b1, powerFailFlagN: 1'b1, backupActive: 1'b0,
      backupGood: 1'b0, supplyLowWarningN: 1'b1};

endpackage

// ### core/ssw_supervisor.sv
// supply supervisor core: reset sequencer, watchdog, chip-select gating,
// supply steering and status. expects synchronous threshold flags and pins.
`timescale 1ns/1ps
`default_nettype none

module ssw_supervisor
   import ssw_pkg::*;
#(
   parameter int RESET_CYCLES    = RESET_TIMEOUT_CYCLES,
   parameter int WATCHDOG_CYCLES = WATCHDOG_TIMEOUT_CYCLES
)
(
   input  wire logic           clock,
   input  wire logic           rstn,
   input  wire ssw_flags_type  flags,
   input  wire logic           manualResetN,
   input  wire logic           watchdogKickIn,
   input  wire logic           chipSelectInN,
   output var  ssw_status_type status
);

   typedef struct packed
   {
      ssw_phase_type  phase;
      logic [31:0]    rstCount;
      logic [31:0]    wdCount;
      logic           kickPrev;
      logic           wdFault;
      logic           csHold;
      logic [15:0]    csCount;
      ssw_status_type out;
   } ssw_state_type;

   localparam logic [31:0] RST_LAST = 32'(RESET_CYCLES - 1);
   localparam logic [31:0] WD_LAST  = 32'(WATCHDOG_CYCLES - 1);
   localparam logic [15:0] CS_LAST  = 16'(CS_HOLD_CYCLES - 1);

   ssw_state_type s;
   ssw_state_type next_s;

   logic trigger;
   logic kickEdge;
   logic resetActive;

   assign status = s.out;

   always_comb
   begin
      next_s = s;
      trigger  = flags.belowReset | ~manualResetN;
      kickEdge = watchdogKickIn != s.kickPrev;
      next_s.kickPrev = watchdogKickIn;

      unique case (s.phase)
         PHASE_HOLD:
         begin
            next_s.rstCount = '0;
            if (!trigger)
            begin
               next_s.phase = PHASE_STRETCH;
            end
         end
         PHASE_STRETCH:
         begin
            if (trigger)
            begin
               next_s.phase    = PHASE_HOLD;
               next_s.rstCount = '0;
            end
            else if (s.rstCount >= RST_LAST)
            begin
               next_s.phase    = PHASE_RUN;
               next_s.rstCount = '0;
            end
            else
            begin
               next_s.rstCount = s.rstCount + 32'h0000_0001;
            end
         end
         PHASE_RUN:
         begin
            if (trigger)
            begin
               next_s.phase = PHASE_HOLD;
            end
         end
         default:
         begin
            next_s.phase = PHASE_HOLD;
         end
      endcase

      resetActive = next_s.phase != PHASE_RUN;
      next_s.out.resetN    = ~resetActive;
      next_s.out.resetHigh = resetActive;

      // cleared by reset or kick edge
      if (resetActive || kickEdge)
      begin
         next_s.wdCount = '0;
         next_s.wdFault = 1'b0;
      end
      else if (s.wdCount >= WD_LAST)
      begin
         next_s.wdFault = 1'b1;
      end
      else
      begin
         next_s.wdCount = s.wdCount + 32'h0000_0001;
      end

      if (flags.belowSwitch)
      begin
         next_s.out.watchdogFaultN = 1'b0;
      end
      else
      begin
         next_s.out.watchdogFaultN = ~next_s.wdFault;
      end

      if (resetActive && s.phase == PHASE_RUN && !chipSelectInN)
      begin
         next_s.csHold  = 1'b1;
         next_s.csCount = '0;
      end
      else if (s.csHold)
      begin
         if (chipSelectInN || s.csCount >= CS_LAST || !resetActive)
         begin
            next_s.csHold = 1'b0;
         end
         else
         begin
            next_s.csCount = s.csCount + 16'h0001;
         end
      end
      if (!resetActive)
      begin
         next_s.out.chipSelectOutN = chipSelectInN;
      end
      else
      begin
         next_s.out.chipSelectOutN = ~(next_s.csHold & ~chipSelectInN);
      end

      next_s.out.powerFailFlagN =
         ~(flags.powerFailSenseIn | flags.belowSwitch);

      if (flags.belowSwitch && flags.belowCell)
      begin
         next_s.out.backupActive = 1'b1;
      end
      else if (!flags.belowReset || !flags.belowCell)
      begin
         next_s.out.backupActive = 1'b0;
      end

      if (flags.belowSwitch)
      begin
         next_s.out.backupGood = 1'b0;
      end
      else if (!resetActive)
      begin
         next_s.out.backupGood = flags.cellGoodLevel;
      end

      next_s.out.supplyLowWarningN = ~flags.atWarningLevel;
   end

   // everything counted on the free clock
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         s <= '{phase: PHASE_HOLD, rstCount: '0, wdCount: '0,
                kickPrev: 1'b0, wdFault: 1'b0, csHold: 1'b0,
                csCount: '0, out: STATUS_RESET};
      end
      else
      begin
         s <= next_s;
      end
   end

   // checks; outputs lag their cause by one edge
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   resetInverse_a: assert property (status.resetHigh == ~status.resetN)
      else $error("active-high reset not inverse of active-low reset");

   manualHold_a: assert property (!manualResetN |=> !status.resetN)
      else $error("reset released while manual reset low");

   stretchStart_a: assert property (
      $fell(trigger) |-> !status.resetN ##1 !status.resetN)
      else $error("reset released right after trigger cleared");

   releaseCount_a: assert property (
      $rose(status.resetN) |-> $past(s.rstCount) == RST_LAST)
      else $error("reset released before timeout completed");

   restartTimer_a: assert property (
      flags.belowReset |=> s.rstCount == '0 && !status.resetN)
      else $error("reset timer not restarted on brownout");

   wdIdle_a: assert property (!status.resetN |-> s.wdCount == '0)
      else $error("watchdog counting during reset");

   wdFault_a: assert property (
      status.resetN && !trigger && !kickEdge && !flags.belowSwitch
      && s.wdCount == WD_LAST |=> !status.watchdogFaultN)
      else $error("watchdog fault not flagged at timeout");

   wdClear_a: assert property (
      kickEdge && !flags.belowSwitch |=> status.watchdogFaultN)
      else $error("kick transition did not clear watchdog fault");

   wdLowSupply_a: assert property (
      flags.belowSwitch |=> !status.watchdogFaultN)
      else $error("watchdog fault high below switch threshold");

   csGate_a: assert property (
      chipSelectInN || (trigger && !status.resetN && !s.csHold)
      |=> status.chipSelectOutN)
      else $error("gated select low without a low request");

   csWindow_a: assert property (
      s.csHold |-> s.csCount <= CS_LAST && !status.resetN)
      else $error("select hold window overran");

   pfFlag_a: assert property (
      flags.powerFailSenseIn || flags.belowSwitch
      |=> !status.powerFailFlagN)
      else $error("power-fail flag not asserted");

   toBattery_a: assert property (
      flags.belowSwitch && flags.belowCell |=> status.backupActive)
      else $error("battery not selected below switch and cell");

   toMain_a: assert property (
      !flags.belowSwitch && (!flags.belowReset || !flags.belowCell)
      |=> !status.backupActive)
      else $error("main supply not reselected");

   goodLow_a: assert property (
      flags.belowSwitch |=> !status.backupGood)
      else $error("battery-good high below switch threshold");

   supply_low_warning_n_a: assert property (
      flags.atWarningLevel |=> !status.supplyLowWarningN)
      else $error("low-line warning missing");

   resetRelease_c: cover property ($rose(status.resetN));
   wdFault_c: cover property ($fell(status.watchdogFaultN));
   csHold_c: cover property (s.csHold && !status.chipSelectOutN);
   battery_c: cover property ($rose(status.backupActive));

endmodule

`default_nettype wire

// ### tb/ssw_host_model.sv
// host processor model: kicks the watchdog, may route fault to reset.
// assumes the supervisor's clock and reset; bench sets the modes.
`timescale 1ns/1ps
`default_nettype none

module ssw_host_model
(
   input  wire logic clock,
   input  wire logic rstn,
   input  wire logic kickEnable,
   input  wire logic routeFault,
   input  wire logic manualN,
   input  wire logic watchdogFaultN,
   output var  logic watchdogKickIn,
   output wire logic manualResetN
);
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         watchdogKickIn <= 1'h0;
      else if (kickEnable)
         watchdogKickIn <= ~watchdogKickIn;
   end

   assign manualResetN = manualN & (~routeFault | watchdogFaultN);
endmodule

`default_nettype wire

// ### tb/supply_supervisor_watchdog_test.sv
// bench for the supply supervisor: reset, watchdog, select gating, flags.
// assumes shortened reset and watchdog counts; host model on the far side.
`timescale 1ns/1ps
`default_nettype none

module supply_supervisor_watchdog_test
   import ssw_pkg::*;
;
   // short counts keep the run small
   localparam int RC = 20;
   localparam int WC = 50;
   logic           clock = 1'h0;
   logic           rstn = 1'h0;
   ssw_flags_type  flags = '0;
   logic           manualN = 1'h1;
   logic           kickEnable = 1'h0;
   logic           routeFault = 1'h0;
   logic           csInN = 1'h1;
   logic           kick;
   logic           mrN;
   ssw_status_type status;
   int             failCount = 0;
   int             nChecks = 0;

   always #5 clock = ~clock;

   ssw_supervisor #(.RESET_CYCLES(RC), .WATCHDOG_CYCLES(WC)) i_ssw_supervisor
   (
      .clock          (clock),
      .rstn           (rstn),
      .flags          (flags),
      .manualResetN   (mrN),
      .watchdogKickIn (kick),
      .chipSelectInN  (csInN),
      .status         (status)
   );

   ssw_host_model i_ssw_host_model
   (
      .clock          (clock),
      .rstn           (rstn),
      .kickEnable     (kickEnable),
      .routeFault     (routeFault),
      .manualN        (manualN),
      .watchdogFaultN (status.watchdogFaultN),
      .watchdogKickIn (kick),
      .manualResetN   (mrN)
   );

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic chk(input string what, input logic e, input logic g);
      nChecks++;
      if (g !== e)
      begin
         failCount++;
         $display("CHECK FAILED %s exp %b got %b", what, e, g);
      end
   endtask

   // reset frees on edge RC+1 after the trigger clears
   task automatic stretch();
      cyc(RC);
      chk("resetN held", 1'h0, status.resetN);
      chk("resetHigh held", 1'h1, status.resetHigh);
      cyc(1);
      chk("resetN freed", 1'h1, status.resetN);
      chk("resetHigh freed", 1'h0, status.resetHigh);
   endtask

   task automatic tally_and_finish();
      if (failCount == 0 && nChecks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      #50000;
      failCount++;
      tally_and_finish();
   end

   initial
   begin
      cyc(12);
      rstn = 1'h1;
      stretch();
      manualN = 1'h0;
      cyc(5);
      chk("resetN manual", 1'h0, status.resetN);
      manualN = 1'h1;
      stretch();
      manualN = 1'h0;
      cyc(2);
      manualN = 1'h1;
      cyc(10);
      flags.belowReset = 1'h1;
      cyc(1);
      flags.belowReset = 1'h0;
      stretch();
      kickEnable = 1'h1;
      cyc(WC * 3);
      chk("fault kicked", 1'h1, status.watchdogFaultN);
      kickEnable = 1'h0;
      cyc(WC - 2);
      chk("fault early", 1'h1, status.watchdogFaultN);
      cyc(6);
      chk("fault late", 1'h0, status.watchdogFaultN);
      kickEnable = 1'h1;
      cyc(1);
      kickEnable = 1'h0;
      cyc(3);
      chk("fault cleared", 1'h1, status.watchdogFaultN);
      routeFault = 1'h1;
      cyc(WC + 6);
      chk("resetN on fault", 1'h0, status.resetN);
      chk("fault in reset", 1'h1, status.watchdogFaultN);
      routeFault = 1'h0;
      kickEnable = 1'h1;
      cyc(RC + 5);
      chk("resetN after fault", 1'h1, status.resetN);
      csInN = 1'h0;
      cyc(2);
      chk("cs run", 1'h0, status.chipSelectOutN);
      flags.belowReset = 1'h1;
      cyc(500);
      chk("cs window", 1'h0, status.chipSelectOutN);
      cyc(505);
      chk("cs forced", 1'h1, status.chipSelectOutN);
      flags.belowReset = 1'h0;
      cyc(RC + 5);
      chk("cs back", 1'h0, status.chipSelectOutN);
      flags.belowReset = 1'h1;
      cyc(5);
      csInN = 1'h1;
      cyc(2);
      chk("cs input high", 1'h1, status.chipSelectOutN);
      csInN = 1'h0;
      cyc(2);
      chk("cs in reset", 1'h1, status.chipSelectOutN);
      flags.belowReset = 1'h0;
      cyc(RC + 5);
      flags.cellGoodLevel = 1'h1;
      flags.powerFailSenseIn = 1'h1;
      flags.atWarningLevel = 1'h1;
      cyc(2);
      chk("cell good", 1'h1, status.backupGood);
      chk("pf sense", 1'h0, status.powerFailFlagN);
      chk("low line", 1'h0, status.supplyLowWarningN);
      flags.powerFailSenseIn = 1'h0;
      flags.atWarningLevel = 1'h0;
      cyc(2);
      chk("pf idle", 1'h1, status.powerFailFlagN);
      chk("line idle", 1'h1, status.supplyLowWarningN);
      flags.belowReset = 1'h1;
      flags.belowSwitch = 1'h1;
      flags.belowCell = 1'h1;
      cyc(2);
      chk("fault low sw", 1'h0, status.watchdogFaultN);
      chk("pf low sw", 1'h0, status.powerFailFlagN);
      chk("good low sw", 1'h0, status.backupGood);
      chk("on battery", 1'h1, status.backupActive);
      flags.belowSwitch = 1'h0;
      cyc(2);
      chk("battery held", 1'h1, status.backupActive);
      chk("fault between", 1'h1, status.watchdogFaultN);
      flags.belowCell = 1'h0;
      cyc(2);
      chk("on main", 1'h0, status.backupActive);
      flags.belowSwitch = 1'h1;
      flags.belowCell = 1'h1;
      cyc(2);
      chk("battery again", 1'h1, status.backupActive);
      flags.belowSwitch = 1'h0;
      cyc(2);
      chk("good held", 1'h0, status.backupGood);
      flags.belowReset = 1'h0;
      stretch();
      chk("main above reset", 1'h0, status.backupActive);
      chk("good after reset", 1'h1, status.backupGood);
      flags.belowCell = 1'h0;
      flags.cellGoodLevel = 1'h0;
      cyc(2);
      chk("cell weak", 1'h0, status.backupGood);
      rstn = 1'h0;
      cyc(2);
      chk("resetN in reset", 1'h0, status.resetN);
      chk("cs in hard reset", 1'h1, status.chipSelectOutN);
      rstn = 1'h1;
      stretch();
      cyc(1);
      chk("cs after reset", 1'h0, status.chipSelectOutN);
      tally_and_finish();
   end
endmodule

`default_nettype wire
